// *** dv/mph_drive_model.sv ***
`timescale 1ns/10ps
module mph_drive_model
(
	input  wire logic mclk,
	input  wire logic step_en,
	input  wire logic step_dir,
	output logic      step_tick,
	output logic      home_sensor_input,
	output logic      torque_hit,
	output logic      z_phase
);
	int         pos_ff  = 0;
	logic [2:0] div_ff  = 3'h0;
	logic       tick_ff = 1'b0;
	// slow pulses keep each z_phase level past the input filter
	always_ff @(posedge mclk)
	begin
		div_ff <= step_en ? div_ff + 3'h1 : 3'h0;
		tick_ff <= step_en && div_ff == 3'h7;
		if (tick_ff && step_en)
			pos_ff <= step_dir ? pos_ff - 1 : pos_ff + 1;
	end
	assign step_tick = tick_ff;
	assign home_sensor_input = pos_ff >= 20;
	assign torque_hit = pos_ff >= 40 || pos_ff <= -40;
	assign z_phase = pos_ff[2:0] == 3'h0;
endmodule : mph_drive_model

// *** dv/tb_top.sv ***
`timescale 1ns/10ps
`include "mph_defines.svh"
module tb_top;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [15:0] addr = 16'h0000;
	logic [15:0] wdata = 16'h0000;
	logic        hs = 1'b0;
	logic        jp = 1'b0;
	logic        jn = 1'b0;
	logic        ce = 1'b1;
	logic        ps = 1'b0;
	logic        pd = 1'b0;
	logic [15:0] tq = 16'h0123;
	logic [15:0] rdata;
	logic        ack, rej, den, dir, tick, sens, trq, zp;
	logic        inm, inpos, hdone, tlo, tlim, s;
	logic [31:0] pos;
	logic [31:0] spd;
	logic [15:0] tlp, tln;
	logic [15:0] v;
	int          num_errors = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	always #2.5 mclk = ~mclk;
	mph_core #(.CYC_PER_MS(10)) i_dut (.mclk(mclk), .rst(rst), .ce(ce),
		.reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
		.reg_rdata(rdata), .reg_ack(ack), .reg_reject(rej),
		.home_start(hs), .jog_pos(jp), .jog_neg(jn), .push_start(ps),
		.push_dir(pd), .home_sensor_input(sens), .torque_hit(trq),
		.z_phase(zp), .step_tick(tick), .push_torque_positive(tq),
		.push_torque_negative(~tq), .step_en(den), .step_dir(dir),
		.speed_cmd(spd), .torque_limit_on(tlo), .torque_limit_pos(tlp),
		.torque_limit_neg(tln), .in_motion_flag(inm),
		.in_position_flag(inpos), .travel_limit_flag(tlim),
		.home_done(hdone), .position(pos));
	mph_drive_model i_drv (.mclk(mclk), .step_en(den), .step_dir(dir),
		.step_tick(tick), .home_sensor_input(sens), .torque_hit(trq),
		.z_phase(zp));
	task automatic end_sim();
		$display("compares %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : end_sim
	task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", n, exp, seen);
		end
	endtask : chk
	// one strobe per call; ack and reject land one cycle after the take
	task automatic acc(logic w, logic [15:0] a, logic [15:0] d);
		@(posedge mclk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
		chk("ack", ack, 1'b1);
		s = rej;
		v = rdata;
	endtask : acc
	task automatic waitfor(int sel, logic lvl);
		for (int i = 0; i < 3000; i++)
		begin
			@(posedge mclk);
			#1;
			if ((sel == 2 ? tlo : sel ? inm : hdone) === lvl)
				return;
		end
		chk("wait", 1'b0, 1'b1);
	endtask : waitfor
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			end_sim();
		end
	end
	initial
	begin
		repeat (8) @(posedge mclk);
		rst <= 1'b0;
		acc(0, `MPH_A_STRT_L, 16'h0);
		chk("start_speed", v, 16'h03e8);
		acc(1, `MPH_A_METH, 16'h0008);
		chk("meth_rej", s, 1'b1);
		acc(1, `MPH_A_RAMP_L, 16'h0000);
		chk("ramp_rej", s, 1'b1);
		acc(1, `MPH_A_JOGS, 16'h0000);
		chk("jog_rej", s, 1'b1);
		acc(1, `MPH_A_NLIM_L, 16'h0001);
		chk("nlim_rej", s, 1'b1);
		acc(1, `MPH_A_METH, 16'h0004);
		chk("meth_ok", s, 1'b0);
		acc(1, `MPH_A_HPOS_L, 16'h1234);
		acc(1, `MPH_A_HSPD, 16'h0032);
		@(posedge mclk);
		hs <= 1'b1;
		@(posedge mclk);
		hs <= 1'b0;
		#1;
		chk("home_dir", dir, 1'b0);
		chk("home_run", den, 1'b1);
		chk("tq_pos", tlp, 16'h0123);
		chk("tq_neg", tln, 16'hfedc);
		waitfor(0, 1'b1);
		chk("home_pos", pos, 32'h1234);
		acc(1, `MPH_A_OPT, 16'h0001);
		acc(1, `MPH_A_JOGD_L, 16'h0005);
		acc(1, `MPH_A_JOGW, 16'h0001);
		@(posedge mclk);
		jp <= 1'b1;
		@(posedge mclk);
		jp <= 1'b0;
		waitfor(1, 1'b1);
		waitfor(1, 1'b0);
		chk("jog_pos", pos, 32'h1239);
		// in-position is registered: it shows one cycle after the last pulse
		@(posedge mclk);
		#1;
		chk("inpos", inpos, 1'b1);
		acc(1, `MPH_A_METH, 16'h0001);
		acc(1, `MPH_A_HOFF_L, 16'h0003);
		acc(1, `MPH_A_HOSP, 16'h0014);
		acc(1, `MPH_A_PUSH_L, 16'h0002);
		// home start is ignored until the post-jog delay has run out
		repeat (20) @(posedge mclk);
		hs <= 1'b1;
		@(posedge mclk);
		hs <= 1'b0;
		#1;
		chk("trq_dir", dir, 1'b1);
		waitfor(2, 1'b1);
		chk("offs_dir", dir, 1'b0);
		chk("offs_spd", spd, 32'h0000_03e8);
		waitfor(0, 1'b1);
		chk("home_pos2", pos, 32'h1234);
		@(posedge mclk);
		ps <= 1'b1;
		pd <= 1'b1;
		@(posedge mclk);
		ps <= 1'b0;
		#1;
		chk("push_dir", dir, 1'b1);
		waitfor(1, 1'b0);
		@(posedge mclk);
		#1;
		chk("push_inpos", inpos, 1'b1);
		acc(1, `MPH_A_PLIM_L, 16'h1000);
		@(posedge mclk);
		#1;
		chk("lim_on", tlim, 1'b1);
		acc(1, `MPH_A_PLIM_L, 16'h0000);
		@(posedge mclk);
		#1;
		chk("lim_off", tlim, 1'b0);
		@(posedge mclk);
		ce <= 1'b0;
		hs <= 1'b1;
		repeat (3) @(posedge mclk);
		ce <= 1'b1;
		hs <= 1'b0;
		#1;
		chk("freeze", den, 1'b0);
		end_sim();
	end
endmodule : tb_top

// *** logic/mph_core.sv ***
`timescale 1ns/10ps
`include "mph_defines.svh"
// Overview of operation
// - methods 0/1 drive positive/negative until torque detection marks the end.
// - method 2 torque-returns positive then seeks Z reversed; 3 seeks Z only.
// - methods 4/5 move positive/negative until the home sensor goes active.
// - methods 6/7 find the sensor, then reverse and seek the Z-phase.
// - home search runs at home speed percent of the top speed.
// - torque homing then moves the home offset distance the opposite way.
// - the offset move runs at offset speed percent of the top speed.
// - the offset move limits torque to the push torque settings.
// - successful homing loads the position with the home position value.
// - a soft limit programmed as zero is disabled for its direction.
// - soft limits are signed; positive limit at or above zero, negative at or below.
// - one ramp time, 1 to 30000 ms, serves acceleration and deceleration.
// - motion starts at the lower of start speed and move speed and never exceeds the top speed.
// - motion flag clears at end of pulses; option 1 also sets in-position after jog and push moves.
// - thrust search continues the programmed pulses after torque is reached.
// - jog moves run at jog speed percent, 1 to 100, of top speed.
// - a limit indicator shows while a soft travel limit is reached.
module mph_core
	import mph_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = `MPH_MS_CYC
)
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [15:0] reg_addr,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_ack,
	output logic             reg_reject,
	input  wire logic        home_start,
	input  wire logic        jog_pos,
	input  wire logic        jog_neg,
	input  wire logic        push_start,
	input  wire logic        push_dir,
	input  wire logic        home_sensor_input,
	input  wire logic        torque_hit,
	input  wire logic        z_phase,
	input  wire logic        step_tick,
	input  wire logic [15:0] push_torque_positive,
	input  wire logic [15:0] push_torque_negative,
	output logic             step_en,
	output logic             step_dir,
	output logic      [31:0] speed_cmd,
	output logic             torque_limit_on,
	output logic      [15:0] torque_limit_pos,
	output logic      [15:0] torque_limit_neg,
	output logic             in_motion_flag,
	output logic             in_position_flag,
	output logic             travel_limit_flag,
	output logic             home_done,
	output logic      [31:0] position
);
	logic [31:0] strt_ff, maxs_ff, ramp_ff, push_ff, jogd_ff;
	logic [31:0] plim_ff, nlim_ff, hoff_ff, hpos_ff;
	logic [15:0] opt_ff, jogs_ff, jogw_ff, meth_ff, hspd_ff, hosp_ff;
	logic [31:0] nxt_strt, nxt_maxs, nxt_ramp, nxt_push, nxt_jogd;
	logic [31:0] nxt_plim, nxt_nlim, nxt_hoff, nxt_hpos;
	logic [15:0] nxt_opt, nxt_jogs, nxt_jogw, nxt_meth, nxt_hspd, nxt_hosp;
	logic [31:0] wv;
	logic [15:0] rdata_ff, nxt_rdata;
	logic        ack_ff, rej_ff, nxt_rej;

	logic [2:0]  sy1_ff, sy2_ff, sy3_ff, flt_ff, nxt_flt;
	logic        sen, trq, zph;

	mph_state_t  state_ff, nxt_state;
	logic        dir_ff, nxt_dir, inpos_ff, nxt_inpos, done_ff, nxt_done;
	logic        homed_ff, nxt_homed, lim_ff, nxt_lim;
	logic [31:0] rem_ff, nxt_rem, tgt_ff, nxt_tgt, pos_ff, nxt_pos;
	logic [31:0] acc_ff, nxt_acc, wpre_ff, nxt_wpre;
	logic [15:0] wms_ff, nxt_wms;
	logic [15:0] tpos_ff, tneg_ff;
	logic        counted, moving, lim_hit, decel, accel, run;

	function automatic logic [31:0] mrg(
		input logic [31:0] old,
		input logic        hi,
		input logic [15:0] wd
	);
		mrg = hi ? {wd, old[15:0]} : {old[31:16], wd};
	endfunction : mrg

	function automatic logic [15:0] half(
		input logic [31:0] v,
		input logic        hi
	);
		half = hi ? v[31:16] : v[15:0];
	endfunction : half

	always_comb
	begin
		nxt_strt = strt_ff;
		nxt_maxs = maxs_ff;
		nxt_ramp = ramp_ff;
		nxt_push = push_ff;
		nxt_jogd = jogd_ff;
		nxt_plim = plim_ff;
		nxt_nlim = nlim_ff;
		nxt_hoff = hoff_ff;
		nxt_hpos = hpos_ff;
		nxt_opt  = opt_ff;
		nxt_jogs = jogs_ff;
		nxt_jogw = jogw_ff;
		nxt_meth = meth_ff;
		nxt_hspd = hspd_ff;
		nxt_hosp = hosp_ff;
		nxt_rej  = 1'b0;
		wv       = 32'h0;
		if (reg_wr)
		begin
			unique case (reg_addr)
				`MPH_A_STRT, `MPH_A_STRT_L:
					nxt_strt = mrg(strt_ff, reg_addr == `MPH_A_STRT, reg_wdata);
				`MPH_A_MAXS, `MPH_A_MAXS_L:
					nxt_maxs = mrg(maxs_ff, reg_addr == `MPH_A_MAXS, reg_wdata);
				`MPH_A_RAMP, `MPH_A_RAMP_L:
				begin
					wv = mrg(ramp_ff, reg_addr == `MPH_A_RAMP, reg_wdata);
					if (wv >= `MPH_RAMP_MIN && wv <= `MPH_RAMP_MAX)
						nxt_ramp = wv;
					else
						nxt_rej = 1'b1;
				end
				`MPH_A_PUSH, `MPH_A_PUSH_L:
					nxt_push = mrg(push_ff, reg_addr == `MPH_A_PUSH, reg_wdata);
				`MPH_A_JOGD, `MPH_A_JOGD_L:
					nxt_jogd = mrg(jogd_ff, reg_addr == `MPH_A_JOGD, reg_wdata);
				`MPH_A_HOFF, `MPH_A_HOFF_L:
					nxt_hoff = mrg(hoff_ff, reg_addr == `MPH_A_HOFF, reg_wdata);
				`MPH_A_HPOS, `MPH_A_HPOS_L:
					nxt_hpos = mrg(hpos_ff, reg_addr == `MPH_A_HPOS, reg_wdata);
				`MPH_A_PLIM, `MPH_A_PLIM_L:
				begin
					wv = mrg(plim_ff, reg_addr == `MPH_A_PLIM, reg_wdata);
					if (!wv[31])
						nxt_plim = wv;
					else
						nxt_rej = 1'b1;
				end
				`MPH_A_NLIM, `MPH_A_NLIM_L:
				begin
					wv = mrg(nlim_ff, reg_addr == `MPH_A_NLIM, reg_wdata);
					if (wv[31] || wv == 32'h0)
						nxt_nlim = wv;
					else
						nxt_rej = 1'b1;
				end
				`MPH_A_OPT:
					if (reg_wdata <= `MPH_OPT_MAX) nxt_opt = reg_wdata;
					else nxt_rej = 1'b1;
				`MPH_A_JOGS:
					if (reg_wdata >= `MPH_PCT_MIN && reg_wdata <= `MPH_PCT_MAX)
						nxt_jogs = reg_wdata;
					else
						nxt_rej = 1'b1;
				`MPH_A_JOGW:
					if (reg_wdata <= `MPH_WAIT_MAX) nxt_jogw = reg_wdata;
					else nxt_rej = 1'b1;
				`MPH_A_METH:
					if (reg_wdata <= `MPH_METH_MAX) nxt_meth = reg_wdata;
					else nxt_rej = 1'b1;
				`MPH_A_HSPD:
					if (reg_wdata <= `MPH_PCT_MAX) nxt_hspd = reg_wdata;
					else nxt_rej = 1'b1;
				`MPH_A_HOSP:
					if (reg_wdata <= `MPH_PCT_MAX) nxt_hosp = reg_wdata;
					else nxt_rej = 1'b1;
				default:
					nxt_rej = 1'b0;
			endcase
		end
	end

	always_comb
	begin
		nxt_rdata = rdata_ff;
		if (reg_rd)
		begin
			unique case (reg_addr)
				`MPH_A_STRT, `MPH_A_STRT_L:
					nxt_rdata = half(strt_ff, reg_addr == `MPH_A_STRT);
				`MPH_A_MAXS, `MPH_A_MAXS_L:
					nxt_rdata = half(maxs_ff, reg_addr == `MPH_A_MAXS);
				`MPH_A_RAMP, `MPH_A_RAMP_L:
					nxt_rdata = half(ramp_ff, reg_addr == `MPH_A_RAMP);
				`MPH_A_PUSH, `MPH_A_PUSH_L:
					nxt_rdata = half(push_ff, reg_addr == `MPH_A_PUSH);
				`MPH_A_JOGD, `MPH_A_JOGD_L:
					nxt_rdata = half(jogd_ff, reg_addr == `MPH_A_JOGD);
				`MPH_A_PLIM, `MPH_A_PLIM_L:
					nxt_rdata = half(plim_ff, reg_addr == `MPH_A_PLIM);
				`MPH_A_NLIM, `MPH_A_NLIM_L:
					nxt_rdata = half(nlim_ff, reg_addr == `MPH_A_NLIM);
				`MPH_A_HOFF, `MPH_A_HOFF_L:
					nxt_rdata = half(hoff_ff, reg_addr == `MPH_A_HOFF);
				`MPH_A_HPOS, `MPH_A_HPOS_L:
					nxt_rdata = half(hpos_ff, reg_addr == `MPH_A_HPOS);
				`MPH_A_POS, `MPH_A_POS_L:
					nxt_rdata = half(pos_ff, reg_addr == `MPH_A_POS);
				`MPH_A_OPT:  nxt_rdata = opt_ff;
				`MPH_A_JOGS: nxt_rdata = jogs_ff;
				`MPH_A_JOGW: nxt_rdata = jogw_ff;
				`MPH_A_METH: nxt_rdata = meth_ff;
				`MPH_A_HSPD: nxt_rdata = hspd_ff;
				`MPH_A_HOSP: nxt_rdata = hosp_ff;
				`MPH_A_STAT:
				begin
					nxt_rdata                = 16'h0;
					nxt_rdata[`MPH_ST_BUSY]  = state_ff != mph_idle;
					nxt_rdata[`MPH_ST_MOVE]  = step_en;
					nxt_rdata[`MPH_ST_INPOS] = inpos_ff;
					nxt_rdata[`MPH_ST_LIM]   = lim_ff;
					nxt_rdata[`MPH_ST_HOMED] = homed_ff;
				end
				default: nxt_rdata = 16'h0;
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			strt_ff  <= `MPH_RST_STRT;
			maxs_ff  <= `MPH_RST_MAXS;
			ramp_ff  <= `MPH_RST_RAMP;
			push_ff  <= `MPH_RST_Z32;
			jogd_ff  <= `MPH_RST_Z32;
			plim_ff  <= `MPH_RST_Z32;
			nlim_ff  <= `MPH_RST_Z32;
			hoff_ff  <= `MPH_RST_Z32;
			hpos_ff  <= `MPH_RST_Z32;
			opt_ff   <= `MPH_RST_Z16;
			jogs_ff  <= `MPH_RST_JOGS;
			jogw_ff  <= `MPH_RST_Z16;
			meth_ff  <= `MPH_RST_Z16;
			hspd_ff  <= `MPH_RST_Z16;
			hosp_ff  <= `MPH_RST_Z16;
			rdata_ff <= 16'h0;
			ack_ff   <= 1'b0;
			rej_ff   <= 1'b0;
		end
		else if (ce)
		begin
			strt_ff  <= nxt_strt;
			maxs_ff  <= nxt_maxs;
			ramp_ff  <= nxt_ramp;
			push_ff  <= nxt_push;
			jogd_ff  <= nxt_jogd;
			plim_ff  <= nxt_plim;
			nlim_ff  <= nxt_nlim;
			hoff_ff  <= nxt_hoff;
			hpos_ff  <= nxt_hpos;
			opt_ff   <= nxt_opt;
			jogs_ff  <= nxt_jogs;
			jogw_ff  <= nxt_jogw;
			meth_ff  <= nxt_meth;
			hspd_ff  <= nxt_hspd;
			hosp_ff  <= nxt_hosp;
			rdata_ff <= nxt_rdata;
			ack_ff   <= reg_wr | reg_rd;
			rej_ff   <= nxt_rej;
		end
	end

	// pins settle only when stages two and three agree
	assign nxt_flt = (sy2_ff & sy3_ff) | (flt_ff & (sy2_ff | sy3_ff));
	assign sen = flt_ff[0];
	assign trq = flt_ff[1];
	assign zph = flt_ff[2];

	assign counted = state_ff inside {mph_jog, mph_h_offs, mph_push_extra};
	assign moving  = state_ff inside {mph_h_trq, mph_h_sense, mph_h_z,
		mph_h_offs, mph_jog, mph_push, mph_push_extra};
	assign step_en = moving && !(counted && rem_ff == 32'h0);
	// homing ignores soft limits: position is not trusted before home
	assign lim_hit = (state_ff inside {mph_jog, mph_push, mph_push_extra}) &&
		(dir_ff ? (nlim_ff != 32'h0 && $signed(pos_ff) <= $signed(nlim_ff))
		        : (plim_ff != 32'h0 && $signed(pos_ff) >= $signed(plim_ff)));
	assign decel   = counted && rem_ff <= acc_ff;
	assign run     = moving && nxt_state == state_ff;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_dir   = dir_ff;
		nxt_rem   = rem_ff;
		nxt_tgt   = tgt_ff;
		nxt_pos   = pos_ff;
		nxt_acc   = acc_ff;
		nxt_wms   = wms_ff;
		nxt_wpre  = wpre_ff;
		nxt_inpos = inpos_ff;
		nxt_done  = 1'b0;
		nxt_homed = homed_ff;
		nxt_lim   = (plim_ff != 32'h0 && $signed(pos_ff) >= $signed(plim_ff)) ||
			(nlim_ff != 32'h0 && $signed(pos_ff) <= $signed(nlim_ff));
		if (step_tick && step_en)
		begin
			nxt_pos = dir_ff ? pos_ff - 32'h1 : pos_ff + 32'h1;
			if (counted)
				nxt_rem = rem_ff - 32'h1;
			if (accel)
				nxt_acc = acc_ff + 32'h1;
		end
		unique case (state_ff)
			mph_idle:
				if (home_start)
				begin
					nxt_inpos = 1'b0;
					nxt_homed = 1'b0;
					nxt_dir   = meth_ff[0];
					nxt_tgt   = mph_pct_speed(maxs_ff, hspd_ff);
					if (meth_ff[2])
						nxt_state = mph_h_sense;
					else if (meth_ff[1:0] == 2'h3)
						nxt_state = mph_h_z;
					else
						nxt_state = mph_h_trq;
				end
				else if (jog_pos || jog_neg)
				begin
					nxt_inpos = 1'b0;
					nxt_dir   = jog_neg;
					nxt_rem   = jogd_ff;
					nxt_tgt   = mph_pct_speed(maxs_ff, jogs_ff);
					nxt_state = mph_jog;
				end
				else if (push_start)
				begin
					nxt_inpos = 1'b0;
					nxt_dir   = push_dir;
					nxt_tgt   = maxs_ff;
					nxt_state = mph_push;
				end
			mph_h_trq:
				if (trq)
				begin
					nxt_dir = !dir_ff;
					if (meth_ff[1:0] == 2'h2)
						nxt_state = mph_h_z;
					else
					begin
						nxt_rem   = hoff_ff;
						nxt_tgt   = mph_pct_speed(maxs_ff, hosp_ff);
						nxt_state = mph_h_offs;
					end
				end
			mph_h_sense:
				if (sen)
				begin
					if (meth_ff[1])
					begin
						nxt_dir   = !dir_ff;
						nxt_state = mph_h_z;
					end
					else
						nxt_state = mph_h_load;
				end
			mph_h_z:
				if (zph)
				begin
					if (meth_ff[2:0] == 3'h2)
					begin
						nxt_dir   = !dir_ff;
						nxt_rem   = hoff_ff;
						nxt_tgt   = mph_pct_speed(maxs_ff, hosp_ff);
						nxt_state = mph_h_offs;
					end
					else
						nxt_state = mph_h_load;
				end
			mph_h_offs:
				if (rem_ff == 32'h0)
					nxt_state = mph_h_load;
			mph_h_load:
			begin
				nxt_pos   = hpos_ff;
				nxt_done  = 1'b1;
				nxt_homed = 1'b1;
				nxt_state = mph_idle;
			end
			mph_jog:
				if (rem_ff == 32'h0 || lim_hit)
				begin
					nxt_inpos = opt_ff[0] && rem_ff == 32'h0;
					nxt_wms   = 16'h0;
					nxt_wpre  = 32'h0;
					nxt_state = mph_jog_wait;
				end
			mph_jog_wait:
				if (wms_ff >= jogw_ff)
					nxt_state = mph_idle;
				else if (wpre_ff == 32'(CYC_PER_MS - 1))
				begin
					nxt_wpre = 32'h0;
					nxt_wms  = wms_ff + 16'h1;
				end
				else
					nxt_wpre = wpre_ff + 32'h1;
			mph_push:
				if (lim_hit)
					nxt_state = mph_idle;
				else if (trq)
				begin
					nxt_rem   = push_ff;
					nxt_state = mph_push_extra;
				end
			mph_push_extra:
				if (rem_ff == 32'h0 || lim_hit)
				begin
					nxt_inpos = opt_ff[0] && rem_ff == 32'h0;
					nxt_state = mph_idle;
				end
		endcase
		if (nxt_state != state_ff)
			nxt_acc = 32'h0;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			{sy1_ff, sy2_ff, sy3_ff, flt_ff} <= 12'h000;
			state_ff <= mph_idle;
			{dir_ff, inpos_ff, done_ff, homed_ff, lim_ff} <= 5'h00;
			{rem_ff, tgt_ff, pos_ff, acc_ff, wpre_ff} <= 160'h0;
			wms_ff   <= 16'h0;
			tpos_ff  <= 16'h0;
			tneg_ff  <= 16'h0;
		end
		else if (ce)
		begin
			sy1_ff   <= {z_phase, torque_hit, home_sensor_input};
			sy2_ff   <= sy1_ff;
			sy3_ff   <= sy2_ff;
			flt_ff   <= nxt_flt;
			state_ff <= nxt_state;
			{dir_ff, inpos_ff, done_ff, homed_ff, lim_ff} <=
				{nxt_dir, nxt_inpos, nxt_done, nxt_homed, nxt_lim};
			{rem_ff, tgt_ff, pos_ff, acc_ff, wpre_ff} <=
				{nxt_rem, nxt_tgt, nxt_pos, nxt_acc, nxt_wpre};
			wms_ff   <= nxt_wms;
			tpos_ff  <= push_torque_positive;
			tneg_ff  <= push_torque_negative;
		end
	end

	mph_ramp u_ramp (
		.mclk       (mclk),
		.rst        (rst),
		.ce         (ce),
		.run        (run),
		.decel      (decel),
		.start_spd  (strt_ff),
		.top_spd    (tgt_ff),
		.ramp_ms    (ramp_ff),
		.cyc_per_ms (32'(CYC_PER_MS)),
		.speed      (speed_cmd),
		.accel      (accel)
	);

	assign reg_rdata         = rdata_ff;
	assign reg_ack           = ack_ff;
	assign reg_reject        = rej_ff;
	assign step_dir          = dir_ff;
	assign torque_limit_on   = state_ff == mph_h_offs;
	assign torque_limit_pos  = tpos_ff;
	assign torque_limit_neg  = tneg_ff;
	assign in_motion_flag    = step_en;
	assign in_position_flag  = inpos_ff;
	assign travel_limit_flag = lim_ff;
	assign home_done         = done_ff;
	assign position          = pos_ff;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	property p_trq_neg;
		state_ff == mph_idle && ce && home_start && meth_ff == 16'h1
		|=> state_ff == mph_h_trq && step_dir;
	endproperty
	a_trq_neg: assert property (p_trq_neg) else $error("bad torque home");
	property p_z_rev;
		state_ff == mph_h_trq && ce && trq && meth_ff == 16'h2
		|=> state_ff == mph_h_z && step_dir != $past(step_dir);
	endproperty
	a_z_rev: assert property (p_z_rev) else $error("z search not reversed");
	property p_sense_end;
		state_ff == mph_h_sense && ce && sen && !meth_ff[1] ##1 ce
		|-> state_ff == mph_h_load ##1 home_done;
	endproperty
	a_sense_end: assert property (p_sense_end) else $error("sensor end lost");
	property p_home_spd;
		state_ff inside {mph_h_trq, mph_h_sense}
		|-> tgt_ff == mph_pct_speed(maxs_ff, hspd_ff) && speed_cmd <= tgt_ff;
	endproperty
	a_home_spd: assert property (p_home_spd) else $error("home speed");
	property p_offs_trq;
		state_ff == mph_h_offs |-> torque_limit_on && tgt_ff ==
			mph_pct_speed(maxs_ff, hosp_ff);
	endproperty
	a_offs_trq: assert property (p_offs_trq) else $error("offset move");
	property p_load;
		state_ff == mph_h_load && ce |=> position == $past(hpos_ff) && home_done;
	endproperty
	a_load: assert property (p_load) else $error("home value not loaded");
	property p_lim_off;
		ce && plim_ff == 32'h0 && nlim_ff == 32'h0 |=> !travel_limit_flag;
	endproperty
	a_lim_off: assert property (p_lim_off) else $error("zero limit acted");
	property p_reject;
		ce && reg_wr && reg_addr == `MPH_A_METH && reg_wdata > `MPH_METH_MAX
		|=> reg_reject && meth_ff == $past(meth_ff);
	endproperty
	a_reject: assert property (p_reject) else $error("bad write taken");
	property p_inpos;
		ce && state_ff == mph_jog && rem_ff == 32'h0 && opt_ff == 16'h1
		|=> in_position_flag && !in_motion_flag;
	endproperty
	a_inpos: assert property (p_inpos) else $error("in-position missing");
	property p_jog_wait;
		state_ff == mph_jog_wait |-> !step_en;
	endproperty
	a_jog_wait: assert property (p_jog_wait) else $error("moved in wait");

	c_home6: cover property (home_done && meth_ff == 16'h6);
	c_jog: cover property (state_ff == mph_jog_wait ##1 state_ff == mph_idle);
	c_push: cover property (state_ff == mph_push_extra && step_tick);

endmodule : mph_core

// *** logic/mph_defines.svh ***
`ifndef MPH_DEFINES_SVH
`define MPH_DEFINES_SVH

// word addresses; two-word values keep the high word at the base address
`define MPH_A_STRT   16'h0800
`define MPH_A_STRT_L 16'h0801
`define MPH_A_MAXS   16'h0802
`define MPH_A_MAXS_L 16'h0803
`define MPH_A_RAMP   16'h0804
`define MPH_A_RAMP_L 16'h0805
`define MPH_A_PUSH   16'h0807
`define MPH_A_PUSH_L 16'h0808
`define MPH_A_OPT    16'h080a
`define MPH_A_JOGS   16'h080f
`define MPH_A_JOGD   16'h0810
`define MPH_A_JOGD_L 16'h0811
`define MPH_A_JOGW   16'h0812
`define MPH_A_PLIM   16'h0813
`define MPH_A_PLIM_L 16'h0814
`define MPH_A_NLIM   16'h0815
`define MPH_A_NLIM_L 16'h0816
`define MPH_A_METH   16'h0900
`define MPH_A_HSPD   16'h0901
`define MPH_A_HOFF   16'h0902
`define MPH_A_HOFF_L 16'h0903
`define MPH_A_HOSP   16'h0904
`define MPH_A_HPOS   16'h0905
`define MPH_A_HPOS_L 16'h0906
`define MPH_A_POS    16'h0920
`define MPH_A_POS_L  16'h0921
`define MPH_A_STAT   16'h0922

`define MPH_RST_STRT 32'h0000_03e8
`define MPH_RST_MAXS 32'h0000_2710
`define MPH_RST_RAMP 32'h0000_0064
`define MPH_RST_JOGS 16'h000a
`define MPH_RST_Z32  32'h0000_0000
`define MPH_RST_Z16  16'h0000

`define MPH_RAMP_MIN 32'h0000_0001
`define MPH_RAMP_MAX 32'h0000_7530
`define MPH_PCT_MAX  16'h0064
`define MPH_PCT_MIN  16'h0001
`define MPH_WAIT_MAX 16'h03e8
`define MPH_METH_MAX 16'h0007
`define MPH_OPT_MAX  16'h0001

`define MPH_ST_BUSY  0
`define MPH_ST_MOVE  1
`define MPH_ST_INPOS 2
`define MPH_ST_LIM   3
`define MPH_ST_HOMED 4

`define MPH_CLK_NS   5
`define MPH_MS_NS    1000000
`define MPH_MS_CYC   (`MPH_MS_NS / `MPH_CLK_NS)

`endif

// *** logic/mph_pkg.sv ***
package mph_pkg;

	typedef enum logic [3:0] {
		mph_idle, mph_h_trq, mph_h_sense, mph_h_z, mph_h_offs, mph_h_load,
		mph_jog, mph_jog_wait, mph_push, mph_push_extra
	} mph_state_t;

	// percentage of the top speed, truncated
	function automatic logic [31:0] mph_pct_speed(
		input logic [31:0] top,
		input logic [15:0] pct
	);
		logic [47:0] prod;
		prod = 48'(top) * 48'(pct);
		mph_pct_speed = 32'(prod / 48'd100);
	endfunction : mph_pct_speed

endpackage : mph_pkg

// *** logic/mph_ramp.sv ***
`timescale 1ns/10ps
module mph_ramp
	import mph_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        run,
	input  wire logic        decel,
	input  wire logic [31:0] start_spd,
	input  wire logic [31:0] top_spd,
	input  wire logic [31:0] ramp_ms,
	input  wire logic [31:0] cyc_per_ms,
	output logic      [31:0] speed,
	output logic             accel
);
	logic [31:0] spd_ff;
	logic [31:0] nxt_spd;
	logic [47:0] acc_ff;
	logic [47:0] nxt_acc;
	logic [47:0] thr;
	logic [47:0] delta;
	logic [47:0] sum;

	// one speed unit per overflow: a span larger than the cycle count
	// stretches the ramp instead of jumping
	always_comb
	begin
		thr     = 48'(ramp_ms) * 48'(cyc_per_ms);
		delta   = (top_spd > start_spd) ? 48'(top_spd - start_spd) : 48'h0;
		sum     = acc_ff + delta;
		nxt_spd = spd_ff;
		nxt_acc = sum;
		if (!run || top_spd <= start_spd)
		begin
			nxt_acc = 48'h0;
			nxt_spd = (top_spd <= start_spd) ? top_spd : start_spd;
		end
		else if (spd_ff < start_spd)
		begin
			// a move never ramps up from below the start speed
			nxt_acc = 48'h0;
			nxt_spd = start_spd;
		end
		else if (sum >= thr)
		begin
			nxt_acc = sum - thr;
			if (decel)
			begin
				if (spd_ff > start_spd)
					nxt_spd = spd_ff - 32'h1;
			end
			else if (spd_ff < top_spd)
				nxt_spd = spd_ff + 32'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			spd_ff <= 32'h0;
			acc_ff <= 48'h0;
		end
		else if (ce)
		begin
			spd_ff <= nxt_spd;
			acc_ff <= nxt_acc;
		end
	end

	assign speed = spd_ff;
	assign accel = run && !decel && spd_ff < top_spd;

	property p_spd_cap;
		@(posedge mclk) disable iff (rst)
		run && $past(run) && $stable(top_spd) |-> speed <= top_spd;
	endproperty
	a_spd_cap: assert property (p_spd_cap) else $error("speed over top");
	c_top_reached: cover property (@(posedge mclk) run && speed == top_spd);

endmodule : mph_ramp
